// ### hdl/fwd_pkg.sv
package fwd_pkg;
    // Register byte offsets on the bus
    localparam logic [7:0] FWD_FEATURE_OFS    = 8'h00;
    localparam logic [7:0] FWD_CNT_LO_OFS     = 8'h04;
    localparam logic [7:0] FWD_CNT_HI_OFS     = 8'h08;
    localparam logic [7:0] FWD_POS_LO_OFS     = 8'h0c;
    localparam logic [7:0] FWD_POS_HI_OFS     = 8'h10;
    localparam logic [7:0] FWD_DRIVE_SEL_OFS  = 8'h14;
    localparam logic [7:0] FWD_COMMAND_OFS    = 8'h18;
    localparam logic [7:0] FWD_ERROR_OFS      = 8'h1c;
    localparam logic [7:0] FWD_STATUS_OFS     = 8'h20;
    localparam logic [7:0] FWD_DATA_OFS       = 8'h24;
    localparam logic [7:0] FWD_CTRL_OFS       = 8'h28;
    localparam logic [7:0] FWD_IMAGE_OFS      = 8'h2c;

    localparam logic [7:0] FWD_CMD_PIO        = 8'h92;
    localparam logic [7:0] FWD_CMD_DMA        = 8'h93;
    localparam logic [7:0] FWD_SEL_SEG_ACT    = 8'h03;
    localparam logic [7:0] FWD_SEL_ONE_ACT    = 8'h07;
    localparam logic [7:0] FWD_SEL_SEG_DEFER  = 8'h0e;
    localparam logic [7:0] FWD_SEL_ACT_DEFER  = 8'h0f;

    localparam int FWD_ST_BUSY_BIT  = 7;
    localparam int FWD_ST_READY_BIT = 6;
    localparam int FWD_ST_SEEK_BIT  = 4;
    localparam int FWD_ST_XFER_BIT  = 3;
    localparam int FWD_ST_FAIL_BIT  = 0;
    localparam int FWD_ER_UNC_BIT   = 6;
    localparam int FWD_ER_ABT_BIT   = 2;
    localparam int FWD_CTRL_FINAL_BIT = 0;

    localparam logic [7:0] FWD_STATUS_RST = 8'h50;
    localparam logic [7:0] FWD_REG_RST    = 8'h00;

    // Count indicators left in the count register
    localparam logic [7:0] FWD_IND_MORE   = 8'h01;
    localparam logic [7:0] FWD_IND_SAVED  = 8'h02;

    // One transfer block is 2 to this power 32-bit words (512 bytes)
    localparam int FWD_BLOCK_SHIFT = 7;

    localparam logic [1:0] FWD_RESP_OKAY   = 2'b00;
    localparam logic [1:0] FWD_RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        FWD_IDLE     = 3'b000,
        FWD_XFER     = 3'b001,
        FWD_SEG_END  = 3'b010,
        FWD_VALIDATE = 3'b011,
        FWD_SAVE     = 3'b100
    } fwd_state_t;
endpackage

// ### hdl/fwd_top.sv
// Overview of operation
// [RULE1] Command 92h starts a register-transfer firmware download.
// [RULE2] Command 93h is the same download, payload moved over the DMA stream.
// [RULE3] Selector 03h is segmented save-and-activate; 07h single-command.
// [RULE4] Selector 0Eh is segmented deferred save; 0Fh activates it; rest reserved.
// [RULE5] Count low register gives bits 7:0 of the block count.
// [RULE6] Count high register gives bits 15:8 of the block count.
// [RULE7] Segment position from position registers, used only with 03h.
// [RULE8] 03h: segments over commands; final one validated, saved, activated.
// [RULE9] After a zero-position segment, other commands may drop unsaved data.
// [RULE10] 07h: whole image in one command, no more segments expected.
// [RULE11] 07h: save, then activate, then report completion. Here activate and completion status come in the same cycle.
// [RULE12] 0Eh: final segment validated, saved as deferred, not activated.
// [RULE13] Deferred image activates at next power-on or on 0Fh.
// [RULE14] 0Fh activates deferred image saved earlier with 0Eh.
// [RULE15] Non-download commands leave unsaved and saved images untouched.
// [RULE16] Segmented completion may leave an indicator in the count register.
// [RULE17] End status: busy 0, ready 1, fault 0, seek 1, xfer 0, corr 0.
// [RULE18] Payload content is opaque; transfer never depends on it.
// [RULE19] Reserved selector or failed validation aborts with failure flag.
// [RULE20] Error register carries only aborted and uncorrectable bits.
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module fwd_top
    import fwd_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [31:0] dma_data,
    input  wire logic        dma_valid,
    output logic             dma_ready,
    output logic             img_wr_valid,
    output logic [23:0]      img_wr_addr,
    output logic [31:0]      img_wr_data,
    output logic             check_start,
    input  wire logic        check_done,
    input  wire logic        check_ok,
    output logic             save_start,
    output logic             save_deferred,
    input  wire logic        save_done,
    input  wire logic        save_ok,
    output logic             activate,
    output logic             activate_deferred,
    output logic             discard_unsaved,
    output logic             other_command,
    output logic [7:0]       other_code,
    input  wire logic        deferred_stored
);
    typedef struct packed {
        fwd_state_t  state;
        logic        awready;
        logic        wready;
        logic        arready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic [7:0]  feature;
        logic [7:0]  cnt_lo;
        logic [7:0]  cnt_hi;
        logic [7:0]  pos_lo;
        logic [7:0]  pos_hi;
        logic [7:0]  drive_sel;
        logic [7:0]  command;
        logic [7:0]  err;
        logic [7:0]  status;
        logic [7:0]  ctrl;
        logic [7:0]  subcmd;
        logic        use_dma;
        logic [23:0] words_left;
        logic [23:0] wptr;
        logic        unsaved;
        logic        zero_seg;
        logic        deferred;
        logic        boot;
        logic        img_wr_valid;
        logic [23:0] img_wr_addr;
        logic [31:0] img_wr_data;
        logic        dma_ready;
        logic        check_start;
        logic        save_start;
        logic        save_deferred;
        logic        activate;
        logic        activate_deferred;
        logic        discard;
        logic        other_cmd;
        logic [7:0]  other_code;
    } fwd_regs_t;
    localparam fwd_regs_t FWD_REGS_RST = '{
        state: FWD_IDLE, status: FWD_STATUS_RST, boot: 1'b1,
        awready: 1'b1, wready: 1'b1, arready: 1'b1,
        default: '0
    };
    logic [1:0] rst_sync;
    logic       rst_int_b;
    fwd_regs_t  r;
    fwd_regs_t  next_r;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_int_b = rst_sync[1];
    always_comb begin
        logic        do_write;
        logic        word_in;
        logic [31:0] word;
        logic [15:0] count16;
        do_write  = 1'b0;
        word_in   = 1'b0;
        word      = '0;
        count16   = {r.cnt_hi, r.cnt_lo};
        next_r = r;
        next_r.img_wr_valid      = 1'b0;
        next_r.check_start       = 1'b0;
        next_r.save_start        = 1'b0;
        next_r.activate          = 1'b0;
        next_r.activate_deferred = 1'b0;
        next_r.discard           = 1'b0;
        next_r.other_cmd         = 1'b0;
        next_r.boot              = 1'b0;
        // [RULE13] power-on activation
        if (r.boot && deferred_stored) begin
            next_r.activate          = 1'b1;
            next_r.activate_deferred = 1'b1;
        end
        if (s_axi_awvalid && r.awready) begin
            next_r.aw_got  = 1'b1;
            next_r.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready) begin
            next_r.w_got  = 1'b1;
            next_r.w_data = s_axi_wdata;
            next_r.w_strb = s_axi_wstrb;
        end
        if (r.bvalid && s_axi_bready) next_r.bvalid = 1'b0;
        if (r.aw_got && r.w_got && !r.bvalid) begin
            do_write       = 1'b1;
            next_r.aw_got  = 1'b0;
            next_r.w_got   = 1'b0;
            next_r.bvalid  = 1'b1;
            next_r.bresp   = FWD_RESP_OKAY;
        end
        next_r.awready = !next_r.aw_got && !next_r.bvalid;
        next_r.wready  = !next_r.w_got && !next_r.bvalid;
        if (do_write) begin
            if (r.aw_addr == FWD_FEATURE_OFS) begin
                if (r.w_strb[0]) next_r.feature = r.w_data[7:0];
            end else if (r.aw_addr == FWD_CNT_LO_OFS) begin
                if (r.w_strb[0]) next_r.cnt_lo = r.w_data[7:0];
            end else if (r.aw_addr == FWD_CNT_HI_OFS) begin
                if (r.w_strb[0]) next_r.cnt_hi = r.w_data[7:0];
            end else if (r.aw_addr == FWD_POS_LO_OFS) begin
                if (r.w_strb[0]) next_r.pos_lo = r.w_data[7:0];
            end else if (r.aw_addr == FWD_POS_HI_OFS) begin
                if (r.w_strb[0]) next_r.pos_hi = r.w_data[7:0];
            end else if (r.aw_addr == FWD_DRIVE_SEL_OFS) begin
                if (r.w_strb[0]) next_r.drive_sel = r.w_data[7:0];
            end else if (r.aw_addr == FWD_CTRL_OFS) begin
                if (r.w_strb[0]) next_r.ctrl = r.w_data[7:0];
            end else if (r.aw_addr == FWD_COMMAND_OFS) begin
                if (r.w_strb[0]) next_r.command = r.w_data[7:0];
            end else if (r.aw_addr == FWD_DATA_OFS) begin
                // [RULE18] opaque payload word
                word_in = r.state == FWD_XFER && !r.use_dma;
                word    = r.w_data;
            end else if (r.aw_addr == FWD_ERROR_OFS ||
                         r.aw_addr == FWD_STATUS_OFS ||
                         r.aw_addr == FWD_IMAGE_OFS) begin
            end else begin
                next_r.bresp = FWD_RESP_SLVERR;
            end
        end
        if (r.rvalid && s_axi_rready) next_r.rvalid = 1'b0;
        if (s_axi_arvalid && r.arready) begin
            next_r.rvalid = 1'b1;
            next_r.rresp  = FWD_RESP_OKAY;
            next_r.rdata  = '0;
            if (s_axi_araddr == FWD_FEATURE_OFS) begin
                next_r.rdata[7:0] = r.feature;
            end else if (s_axi_araddr == FWD_CNT_LO_OFS) begin
                next_r.rdata[7:0] = r.cnt_lo;
            end else if (s_axi_araddr == FWD_CNT_HI_OFS) begin
                next_r.rdata[7:0] = r.cnt_hi;
            end else if (s_axi_araddr == FWD_POS_LO_OFS) begin
                next_r.rdata[7:0] = r.pos_lo;
            end else if (s_axi_araddr == FWD_POS_HI_OFS) begin
                next_r.rdata[7:0] = r.pos_hi;
            end else if (s_axi_araddr == FWD_DRIVE_SEL_OFS) begin
                next_r.rdata[7:0] = r.drive_sel;
            end else if (s_axi_araddr == FWD_COMMAND_OFS) begin
                next_r.rdata[7:0] = r.command;
            end else if (s_axi_araddr == FWD_ERROR_OFS) begin
                next_r.rdata[7:0] = r.err;
            end else if (s_axi_araddr == FWD_STATUS_OFS) begin
                next_r.rdata[7:0] = r.status;
            end else if (s_axi_araddr == FWD_DATA_OFS) begin
            end else if (s_axi_araddr == FWD_CTRL_OFS) begin
                next_r.rdata[7:0] = r.ctrl;
            end else if (s_axi_araddr == FWD_IMAGE_OFS) begin
                next_r.rdata[2:0] = {r.zero_seg, r.unsaved, r.deferred};
            end else begin
                next_r.rresp = FWD_RESP_SLVERR;
            end
        end
        next_r.arready = !next_r.rvalid;
        // DMA payload path, stalls the source whenever not in transfer
        if (r.dma_ready && dma_valid) begin
            word_in = 1'b1;
            word    = dma_data;
        end
        case (r.state)
            FWD_IDLE: begin
                if (do_write && r.aw_addr == FWD_COMMAND_OFS &&
                    r.w_strb[0]) begin
                    next_r.err    = '0;
                    next_r.status = FWD_STATUS_RST;
                    // [RULE1] [RULE2] command decode
                    if (r.w_data[7:0] == FWD_CMD_PIO ||
                        r.w_data[7:0] == FWD_CMD_DMA) begin
                        next_r.use_dma = r.w_data[7:0] == FWD_CMD_DMA;
                        next_r.subcmd  = r.feature;
                        // [RULE5] [RULE6] block count assembly
                        next_r.words_left = 24'(count16) << FWD_BLOCK_SHIFT;
                        // [RULE3] segmented and single selectors
                        if (r.feature == FWD_SEL_SEG_ACT) begin
                            // [RULE7] position only here
                            next_r.wptr = 24'({r.pos_hi, r.pos_lo})
                                << FWD_BLOCK_SHIFT;
                            next_r.zero_seg = {r.pos_hi, r.pos_lo} == 16'h0000;
                            next_r.unsaved = 1'b1;
                            next_r.state   = FWD_XFER;
                        end else if (r.feature == FWD_SEL_ONE_ACT) begin
                            // [RULE10] whole image from word zero
                            next_r.wptr    = '0;
                            next_r.unsaved = 1'b1;
                            next_r.state   = FWD_XFER;
                        end else if (r.feature == FWD_SEL_SEG_DEFER) begin
                            // [RULE4] deferred segments append in order
                            if (!r.unsaved) next_r.wptr = '0;
                            next_r.unsaved = 1'b1;
                            next_r.state   = FWD_XFER;
                        end else if (r.feature == FWD_SEL_ACT_DEFER &&
                                     r.deferred) begin
                            // [RULE14] [RULE13] activate on request
                            next_r.activate          = 1'b1;
                            next_r.activate_deferred = 1'b1;
                            next_r.deferred          = 1'b0;
                        end else begin
                            // [RULE19] reserved selector aborts
                            next_r.err[FWD_ER_ABT_BIT]    = 1'b1;
                            next_r.status[FWD_ST_FAIL_BIT] = 1'b1;
                        end
                        if (next_r.state == FWD_XFER) begin
                            next_r.status[FWD_ST_XFER_BIT] = 1'b1;
                            if (count16 == 16'h0000) begin
                                next_r.state  = FWD_SEG_END;
                                next_r.status = 8'(1 << FWD_ST_BUSY_BIT);
                            end
                        end
                    end else begin
                        // [RULE15] images untouched by others
                        next_r.other_cmd  = 1'b1;
                        next_r.other_code = r.w_data[7:0];
                        // [RULE9] drop unsaved after zero segment
                        if (r.unsaved && r.zero_seg) begin
                            next_r.discard  = 1'b1;
                            next_r.unsaved  = 1'b0;
                            next_r.zero_seg = 1'b0;
                        end
                    end
                end
            end
            FWD_XFER: begin
                // [RULE18] words counted, never inspected
                if (word_in) begin
                    next_r.img_wr_valid = 1'b1;
                    next_r.img_wr_addr  = r.wptr;
                    next_r.img_wr_data  = word;
                    next_r.wptr         = r.wptr + 24'h000001;
                    next_r.words_left   = r.words_left - 24'h000001;
                    if (r.words_left == 24'h000001) begin
                        next_r.state  = FWD_SEG_END;
                        next_r.status = 8'(1 << FWD_ST_BUSY_BIT);
                    end
                end
            end
            FWD_SEG_END: begin
                // [RULE8] [RULE12] final segment goes to check
                if (r.subcmd == FWD_SEL_ONE_ACT ||
                    r.ctrl[FWD_CTRL_FINAL_BIT]) begin
                    next_r.check_start = 1'b1;
                    next_r.state       = FWD_VALIDATE;
                end else begin
                    // [RULE16] more segments expected
                    next_r.cnt_lo = FWD_IND_MORE;
                    next_r.status = FWD_STATUS_RST;
                    next_r.state  = FWD_IDLE;
                end
            end
            FWD_VALIDATE: begin
                if (check_done) begin
                    if (check_ok) begin
                        next_r.save_start    = 1'b1;
                        next_r.save_deferred = r.subcmd == FWD_SEL_SEG_DEFER;
                        next_r.state         = FWD_SAVE;
                    end else begin
                        // [RULE19] validation failure aborts
                        next_r.err[FWD_ER_ABT_BIT] = 1'b1;
                        next_r.status = FWD_STATUS_RST;
                        next_r.status[FWD_ST_FAIL_BIT] = 1'b1;
                        next_r.unsaved  = 1'b0;
                        next_r.zero_seg = 1'b0;
                        next_r.state    = FWD_IDLE;
                    end
                end
            end
            FWD_SAVE: begin
                if (save_done) begin
                    // [RULE17] end status
                    next_r.status   = FWD_STATUS_RST;
                    next_r.unsaved  = 1'b0;
                    next_r.zero_seg = 1'b0;
                    next_r.state    = FWD_IDLE;
                    if (!save_ok) begin
                        // [RULE20] save failure is uncorrectable
                        next_r.err[FWD_ER_UNC_BIT] = 1'b1;
                        next_r.status[FWD_ST_FAIL_BIT] = 1'b1;
                    end else if (r.subcmd == FWD_SEL_SEG_DEFER) begin
                        // [RULE12] kept but not activated
                        next_r.deferred = 1'b1;
                        next_r.cnt_lo   = FWD_IND_SAVED;
                    end else begin
                        // [RULE11] activate after save, completion status set in the same cycle
                        next_r.activate = 1'b1;
                        if (r.subcmd == FWD_SEL_SEG_ACT) begin
                            next_r.cnt_lo = FWD_IND_SAVED;
                        end
                    end
                end
            end
            default: next_r.state = FWD_IDLE;
        endcase
        next_r.dma_ready = next_r.state == FWD_XFER && next_r.use_dma;
    end
    always_ff @(posedge mclk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            r <= FWD_REGS_RST;
        end else begin
            r <= next_r;
        end
    end
    assign s_axi_awready     = r.awready;
    assign s_axi_wready      = r.wready;
    assign s_axi_bresp       = r.bresp;
    assign s_axi_bvalid      = r.bvalid;
    assign s_axi_arready     = r.arready;
    assign s_axi_rdata       = r.rdata;
    assign s_axi_rresp       = r.rresp;
    assign s_axi_rvalid      = r.rvalid;
    assign dma_ready         = r.dma_ready;
    assign img_wr_valid      = r.img_wr_valid;
    assign img_wr_addr       = r.img_wr_addr;
    assign img_wr_data       = r.img_wr_data;
    assign check_start       = r.check_start;
    assign save_start        = r.save_start;
    assign save_deferred     = r.save_deferred;
    assign activate          = r.activate;
    assign activate_deferred = r.activate_deferred;
    assign discard_unsaved   = r.discard;
    assign other_command     = r.other_cmd;
    assign other_code        = r.other_code;
endmodule

// ### tb/fwd_nv_model.sv
`timescale 1ns/1ps
module fwd_nv_model (
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic check_start,
    input  wire logic save_start,
    input  wire logic bad_check,
    input  wire logic slow,
    output logic      check_done,
    output logic      check_ok,
    output logic      save_done,
    output logic      save_ok
);
    logic [4:0] cp, sp;
    logic       fl;
    always @(posedge mclk or negedge rst_b)
        if (!rst_b)
            {cp, sp, fl} <= '0;
        else
            {cp, sp, fl} <= {cp[3:0], check_start, sp[3:0], save_start, ~fl};
    assign check_done = slow ? cp[4] : cp[0];
    assign save_done  = slow ? sp[4] : sp[0];
    // Result toggles outside done, so a stale level is never trusted
    assign check_ok   = check_done ? !bad_check : fl;
    assign save_ok    = save_done ? 1'b1 : fl;
endmodule

// ### tb/fwd_top_monitor.sv
`timescale 1ns/1ps
module fwd_top_monitor (
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        dma_valid,
    input wire logic        dma_ready,
    input wire logic [31:0] dma_data,
    input wire logic        img_wr_valid,
    input wire logic [31:0] img_wr_data,
    input wire logic        check_start,
    input wire logic        check_done,
    input wire logic        check_ok,
    input wire logic        save_start,
    input wire logic        save_deferred,
    input wire logic        save_done,
    input wire logic        save_ok,
    input wire logic        activate,
    input wire logic        activate_deferred,
    input wire logic        discard_unsaved,
    input wire logic        other_command
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_dma_word_out: assert property (dma_valid && dma_ready |=>
        img_wr_valid && img_wr_data == $past(dma_data)) else $error("dma word lost");
    a_save_after_ok: assert property (check_done && check_ok |->
        ##[1:4] save_start) else $error("no save after good image");
    a_bad_no_save: assert property (check_done && !check_ok |=>
        !save_start [*4]) else $error("save after bad image");
    a_defer_quiet: assert property (save_done && save_ok && save_deferred
        |=> !activate [*4]) else $error("deferred image activated");
    a_act_pair: assert property (activate_deferred |-> activate)
        else $error("deferred activation without activate");
    a_other_quiet: assert property (other_command |->
        !save_start && !check_start && !img_wr_valid) else $error("image touched");
    a_discard_cause: assert property (discard_unsaved |->
        other_command || $past(other_command)) else $error("stray discard");
    a_check_once: assert property (check_start |=> !check_start [*3])
        else $error("validation started twice");
endmodule
bind fwd_top fwd_top_monitor mon (.*);

// ### tb/tb_fwd_top.sv
`timescale 1ns/1ps
module tb_fwd_top
    import fwd_pkg::*;
;
    int          failures, tests_run, cyc, exp_a, img_n, act_n, def_n, disc_n;
    logic [31:0] q[$];
    logic [31:0] d, s_axi_wdata, s_axi_rdata, dma_data, img_wr_data;
    logic [7:0]  f, s_axi_awaddr, s_axi_araddr, other_code;
    logic [23:0] img_wr_addr;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  r, s_axi_bresp, s_axi_rresp;
    logic mclk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, dma_valid, dma_ready, img_wr_valid, check_start;
    logic check_done, check_ok, save_start, save_deferred, save_done, save_ok;
    logic activate, activate_deferred, discard_unsaved, other_command;
    logic deferred_stored, bad_check, slow;
    fwd_top dut (.*);
    fwd_nv_model nv (.*);
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic chk(input string n, input logic [31:0] e, s);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results;
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ad, dd;
        {ad, dd} = 2'b00;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
        while (!(ad && dd)) begin
            @(posedge mclk);
            if (s_axi_awready && !ad) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && !dd) s_axi_wvalid <= 1'b0;
            ad |= s_axi_awready;
            dd |= s_axi_wready;
        end
        do @(posedge mclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge mclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(n, e, d);
    endtask
    // Issue one command, feed its payload, poll until neither busy nor transfer
    task automatic go(input logic [7:0] c, s, input logic [15:0] n, p, input int e);
        logic [31:0] v;
        exp_a = e;
        wr(FWD_FEATURE_OFS, {24'h0, s});
        wr(FWD_CNT_LO_OFS, {24'h0, n[7:0]});
        wr(FWD_CNT_HI_OFS, {24'h0, n[15:8]});
        wr(FWD_POS_LO_OFS, {24'h0, p[7:0]});
        wr(FWD_POS_HI_OFS, {24'h0, p[15:8]});
        wr(FWD_COMMAND_OFS, {24'h0, c});
        if (c == FWD_CMD_DMA) dma_valid <= 1'b1;
        else for (int i = 0; i < 128 * int'(n); i++) begin
            v = $urandom;
            q.push_back(v);
            wr(FWD_DATA_OFS, v);
        end
        do rd(FWD_STATUS_OFS); while (d[7] || d[3]);
        dma_valid <= 1'b0;
    endtask
    always @(posedge mclk) begin
        if (dma_valid && dma_ready) begin
            q.push_back(dma_data);
            dma_data <= $urandom;
        end
        if (img_wr_valid) begin
            chk("addr", 32'(exp_a), {8'h0, img_wr_addr});
            chk("word", q.pop_front(), img_wr_data);
            exp_a++;
            img_n++;
        end
        act_n += int'(activate);
        def_n += int'(activate_deferred);
        disc_n += int'(discard_unsaved);
        cyc++;
        if (cyc == 40000) begin
            failures++;
            results;
        end
    end
    initial begin
        {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, dma_valid} = '0;
        {deferred_stored, bad_check, slow, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, dma_data, s_axi_bready, s_axi_rready, s_axi_wstrb} = {64'h0, 6'h3f};
        void'($urandom(32'hdd8a36af));
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        rchk("status", FWD_STATUS_OFS, 32'h50);
        rd(8'hfc);
        chk("resp", {30'h0, FWD_RESP_SLVERR}, {30'h0, r});
        wr(8'hfc, 32'h0);
        chk("bresp", {30'h0, FWD_RESP_SLVERR}, {30'h0, r});
        go(FWD_CMD_PIO, FWD_SEL_ONE_ACT, 16'h1, 16'h1, 0);
        chk("status", 32'h50, d);
        chk("acts", 1, act_n);
        chk("words", 128, img_n);
        wr(FWD_CTRL_OFS, 32'h0);
        go(FWD_CMD_PIO, FWD_SEL_SEG_ACT, 16'h1, 16'h0, 0);
        rchk("more", FWD_CNT_LO_OFS, {24'h0, FWD_IND_MORE});
        go(8'he7, 8'h0, 16'h0, 16'h0, 0);
        chk("discard", 1, disc_n);
        chk("code", 32'he7, 32'(other_code));
        chk("quiet", 1, act_n);
        wr(FWD_CTRL_OFS, 32'h1);
        go(FWD_CMD_PIO, FWD_SEL_SEG_ACT, 16'h1, 16'h1, 128);
        chk("acts", 2, act_n);
        rchk("saved", FWD_CNT_LO_OFS, {24'h0, FWD_IND_SAVED});
        do f = 8'($urandom); while (f inside {8'h03, 8'h07, 8'h0e, 8'h0f});
        go(FWD_CMD_PIO, f, 16'h0, 16'h0, 0);
        chk("status", 32'h51, d);
        rchk("error", FWD_ERROR_OFS, 32'h04);
        go(FWD_CMD_DMA, FWD_SEL_SEG_DEFER, 16'h1, 16'h1, 0);
        chk("acts", 2, act_n);
        chk("words", 512, img_n);
        go(FWD_CMD_DMA, FWD_SEL_ACT_DEFER, 16'h0, 16'h0, 0);
        chk("deferred", 1, def_n);
        {bad_check, slow} <= 2'b11;
        go(FWD_CMD_DMA, FWD_SEL_SEG_ACT, 16'h1, 16'h0, 0);
        chk("status", 32'h51, d);
        rchk("error", FWD_ERROR_OFS, 32'h04);
        deferred_stored <= 1'b1;
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (6) @(posedge mclk);
        chk("boot", 2, def_n);
        results;
    end
endmodule
